//--- usbsd_pkg.sv
// Package for the string descriptor byte bank: offsets, sizes, carriers.
// Assumes one clock and synchronous active-high reset in all users.
package usbsd_pkg;

  localparam logic [7:0] SERIAL_BASE = 8'h30;
  localparam logic [7:0] SERIAL_LAST = 8'h4f;
  localparam logic [7:0] MAKER_BASE = 8'h50;
  localparam logic [7:0] MAKER_LAST = 8'h8f;
  localparam logic [7:0] PRODUCT_BASE = 8'h90;
  localparam logic [7:0] PRODUCT_LAST = 8'hcf;
  localparam int SERIAL_DEPTH = 32;
  localparam int STRING_DEPTH = 64;
  localparam logic [7:0] STRING_RESET = 8'h00;
  localparam logic [7:0] SERIAL_INDEX = 8'h01;
  localparam logic [7:0] PRODUCT_INDEX = 8'h02;
  localparam logic [7:0] MAKER_INDEX = 8'h03;

  typedef enum logic [1:0] {
    DESC_IDLE,
    DESC_SEND
  } usbsd_state_e;

  // Register access from the loaders
  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } usbsd_cfg_s;

  // Byte stream toward the descriptor-return logic
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } usbsd_byte_s;

endpackage : usbsd_pkg

//--- usbsd_string_bank.sv
// String descriptor byte bank: serial, maker and product arrays and a byte streamer.
// Assumes loader writes and descriptor requests are synchronous to clock.
//
// Contract
// - String index 1 returns the serial byte array.
// - Serial bytes take writes only while custom_serial_enable is 1.
// - Writable serial bytes may come from EEPROM load or SMBus host.
// - Serial bytes hold a factory default, no fixed reset pattern.
// - String index 3 is served only when maker length exceeds zero.
// - Maker string returns maker_string_length bytes, clipped to 64.
// - String index 2 is served only when product length exceeds zero.
// - Product string returns product_string_length bytes, clipped to 64.
// - Serial bytes sit at addresses 30h to 4Fh, one byte each.
// - Maker bytes sit at 50h to 8Fh, read-write, reset to zero.
// - Product bytes sit at 90h to CFh, reset to zero.
`timescale 1ns/1ps
`default_nettype none

module usbsd_string_bank #(
  parameter logic [255:0] SERIAL_DEFAULT = {32{8'h30}}
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Settings
  input wire logic custom_serial_enable,
  input wire logic [7:0] maker_string_length,
  input wire logic [7:0] product_string_length,
  // Loader register port
  input wire usbsd_pkg::usbsd_cfg_s cfg,
  output logic [7:0] rdData,
  // Descriptor request and byte stream
  input wire logic descReq,
  input wire logic [7:0] descIndex,
  output logic descBusy,
  output logic descReject,
  output usbsd_pkg::usbsd_byte_s descOut
);

  typedef struct packed {
    logic [usbsd_pkg::SERIAL_DEPTH-1:0][7:0] serial_byte;
    logic [usbsd_pkg::STRING_DEPTH-1:0][7:0] maker_string_byte;
    logic [usbsd_pkg::STRING_DEPTH-1:0][7:0] product_string_byte;
    usbsd_pkg::usbsd_state_e state;
    logic [1:0] sel;
    logic [6:0] ptr;
    logic [6:0] remain;
    logic [7:0] rd;
    logic reject;
    usbsd_pkg::usbsd_byte_s out;
  } usbsd_bank_s;

  usbsd_bank_s st_reg;
  usbsd_bank_s st_next;

  logic inSerial;
  logic inMaker;
  logic inProduct;
  logic [7:0] offSerial;
  logic [7:0] offMaker;
  logic [7:0] offProduct;
  logic [7:0] curByte;
  logic [6:0] lenClip;

  assign inSerial = cfg.addr >= usbsd_pkg::SERIAL_BASE && cfg.addr <= usbsd_pkg::SERIAL_LAST;
  assign inMaker = cfg.addr >= usbsd_pkg::MAKER_BASE && cfg.addr <= usbsd_pkg::MAKER_LAST;
  assign inProduct = cfg.addr >= usbsd_pkg::PRODUCT_BASE && cfg.addr <= usbsd_pkg::PRODUCT_LAST;
  assign offSerial = cfg.addr - usbsd_pkg::SERIAL_BASE;
  assign offMaker = cfg.addr - usbsd_pkg::MAKER_BASE;
  assign offProduct = cfg.addr - usbsd_pkg::PRODUCT_BASE;

  always_comb
  begin
    case (st_reg.sel)
      2'd1: curByte = st_reg.serial_byte[st_reg.ptr[4:0]];
      2'd2: curByte = st_reg.product_string_byte[st_reg.ptr[5:0]];
      default: curByte = st_reg.maker_string_byte[st_reg.ptr[5:0]];
    endcase
  end

  always_comb
  begin
    lenClip = 7'd0;
    st_next = st_reg;
    st_next.out.valid = 1'b0;
    st_next.out.last = 1'b0;
    st_next.reject = 1'b0;
    // Loader writes; the EEPROM loader and SMBus host share this port
    if (cfg.wrEn)
    begin
      if (inSerial && custom_serial_enable)
        st_next.serial_byte[offSerial[4:0]] = cfg.wrData;
      if (inMaker)
        st_next.maker_string_byte[offMaker[5:0]] = cfg.wrData;
      if (inProduct)
        st_next.product_string_byte[offProduct[5:0]] = cfg.wrData;
    end
    // Unmapped addresses read as zero
    if (inSerial)
      st_next.rd = st_reg.serial_byte[offSerial[4:0]];
    else if (inMaker)
      st_next.rd = st_reg.maker_string_byte[offMaker[5:0]];
    else if (inProduct)
      st_next.rd = st_reg.product_string_byte[offProduct[5:0]];
    else
      st_next.rd = 8'h00;
    case (st_reg.state)
      usbsd_pkg::DESC_IDLE:
      begin
        if (descReq)
        begin
          st_next.ptr = 7'd0;
          if (descIndex == usbsd_pkg::SERIAL_INDEX)
          begin
            st_next.sel = 2'd1;
            st_next.remain = 7'(usbsd_pkg::SERIAL_DEPTH);
            st_next.state = usbsd_pkg::DESC_SEND;
          end
          else if (descIndex == usbsd_pkg::MAKER_INDEX && maker_string_length != 8'h00)
          begin
            // Lengths above the array depth are clipped so reads stay in range
            lenClip = (maker_string_length > 8'(usbsd_pkg::STRING_DEPTH)) ?
              7'(usbsd_pkg::STRING_DEPTH) : maker_string_length[6:0];
            st_next.sel = 2'd3;
            st_next.remain = lenClip;
            st_next.state = usbsd_pkg::DESC_SEND;
          end
          else if (descIndex == usbsd_pkg::PRODUCT_INDEX && product_string_length != 8'h00)
          begin
            lenClip = (product_string_length > 8'(usbsd_pkg::STRING_DEPTH)) ?
              7'(usbsd_pkg::STRING_DEPTH) : product_string_length[6:0];
            st_next.sel = 2'd2;
            st_next.remain = lenClip;
            st_next.state = usbsd_pkg::DESC_SEND;
          end
          else
            st_next.reject = 1'b1;
        end
      end
      usbsd_pkg::DESC_SEND:
      begin
        st_next.out.valid = 1'b1;
        st_next.out.data = curByte;
        st_next.out.last = (st_reg.remain == 7'd1);
        st_next.ptr = st_reg.ptr + 7'd1;
        st_next.remain = st_reg.remain - 7'd1;
        if (st_reg.remain == 7'd1)
          st_next.state = usbsd_pkg::DESC_IDLE;
      end
      default: st_next.state = usbsd_pkg::DESC_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg <= '0;
      // Serial bytes return to the factory value, not to zero
      st_reg.serial_byte <= SERIAL_DEFAULT;
      st_reg.state <= usbsd_pkg::DESC_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign rdData = st_reg.rd;
  assign descBusy = (st_reg.state == usbsd_pkg::DESC_SEND);
  assign descReject = st_reg.reject;
  assign descOut = st_reg.out;

  // Assertions
  property p_serial_locked;
    @(posedge clock) disable iff (rst)
    (cfg.wrEn && inSerial && !custom_serial_enable) |=>
      st_reg.serial_byte == $past(st_reg.serial_byte);
  endproperty
  a_serial_locked: assert property (p_serial_locked) else $error("Serial write while locked");

  property p_serial_write;
    @(posedge clock) disable iff (rst)
    (cfg.wrEn && inSerial && custom_serial_enable) |=>
      st_reg.serial_byte[$past(offSerial[4:0])] == $past(cfg.wrData);
  endproperty
  a_serial_write: assert property (p_serial_write) else $error("Serial write lost");

  property p_maker_write;
    @(posedge clock) disable iff (rst)
    (cfg.wrEn && inMaker) |=> st_reg.maker_string_byte[$past(offMaker[5:0])] == $past(cfg.wrData);
  endproperty
  a_maker_write: assert property (p_maker_write) else $error("Maker write lost");

  property p_product_write;
    @(posedge clock) disable iff (rst)
    (cfg.wrEn && inProduct) |=>
      st_reg.product_string_byte[$past(offProduct[5:0])] == $past(cfg.wrData);
  endproperty
  a_product_write: assert property (p_product_write) else $error("Product write lost");

  sequence s_serial_start;
    !descBusy && descReq && descIndex == usbsd_pkg::SERIAL_INDEX;
  endsequence
  property p_serial_len;
    @(posedge clock) disable iff (rst)
    s_serial_start |=> descBusy [*8] ##24 descBusy
      ##1 (!descBusy && descOut.valid && descOut.last);
  endproperty
  a_serial_len: assert property (p_serial_len) else $error("Serial string too short");

  property p_maker_zero;
    @(posedge clock) disable iff (rst)
    (!descBusy && descReq && descIndex == usbsd_pkg::MAKER_INDEX && maker_string_length == 8'h00)
      |=> descReject && !descBusy;
  endproperty
  a_maker_zero: assert property (p_maker_zero) else $error("Maker served at zero length");

  property p_product_zero;
    @(posedge clock) disable iff (rst)
    (!descBusy && descReq && descIndex == usbsd_pkg::PRODUCT_INDEX &&
      product_string_length == 8'h00) |=> descReject && !descBusy;
  endproperty
  a_product_zero: assert property (p_product_zero) else $error("Product served at zero length");

  property p_maker_one;
    @(posedge clock) disable iff (rst)
    (!descBusy && descReq && descIndex == usbsd_pkg::MAKER_INDEX && maker_string_length == 8'h01)
      |=> ##1 descOut.valid && descOut.last ##1 !descOut.valid;
  endproperty
  a_maker_one: assert property (p_maker_one) else $error("Maker length one wrong");

  property p_product_two;
    @(posedge clock) disable iff (rst)
    (!descBusy && descReq && descIndex == usbsd_pkg::PRODUCT_INDEX &&
      product_string_length == 8'h02) |=> ##1 descOut.valid && !descOut.last ##1 descOut.last;
  endproperty
  a_product_two: assert property (p_product_two) else $error("Product length two wrong");

  property p_no_overrun;
    @(posedge clock) disable iff (rst)
    descBusy |-> st_reg.remain != 7'd0 && st_reg.ptr <= 7'(usbsd_pkg::STRING_DEPTH);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("Stream past array end");

endmodule : usbsd_string_bank

`default_nettype wire

//--- usbsd_host_model.sv
// Host-side model: asks for string descriptors and collects the returned bytes.
// Assumes it shares the bank's clock and sees its registered byte stream.
`timescale 1ns/1ps
`default_nettype none

module usbsd_host_model (
  // Clock
  input wire logic clock,
  // Descriptor stream from the bank
  input wire logic descBusy,
  input wire logic descReject,
  input wire usbsd_pkg::usbsd_byte_s descOut,
  // Request toward the bank
  output var logic descReq,
  output var logic [7:0] descIndex
);
  logic [7:0] got [0:63];
  int nGot;
  logic rej;
  logic busySeen;
  logic lastSeen;

  initial
  begin
    descReq = 1'b0;
    descIndex = 8'h00;
  end

  // Waits out a running stream first, since a request then would be dropped
  task fetch(input logic [7:0] idx);
    int i;
    nGot = 0;
    rej = 1'b0;
    busySeen = 1'b0;
    lastSeen = 1'b0;
    while (descBusy === 1'b1)
      @(posedge clock);
    @(posedge clock);
    descReq <= 1'b1;
    descIndex <= idx;
    for (i = 0; i < 80; i++)
    begin
      @(posedge clock);
      if (i == 0)
        descReq <= 1'b0;
      #1;
      if (descReject === 1'b1)
        rej = 1'b1;
      if (descBusy === 1'b1)
        busySeen = 1'b1;
      if (descOut.valid === 1'b1 && descOut.last === 1'b1)
        lastSeen = 1'b1;
      if (descOut.valid === 1'b1 && nGot < 64)
      begin
        got[nGot] = descOut.data;
        nGot++;
      end
      if (rej === 1'b1 || (descOut.valid === 1'b1 && descOut.last === 1'b1))
        break;
    end
  endtask : fetch
endmodule : usbsd_host_model

`default_nettype wire

//--- usb_string_descriptor_bank_tb.sv
// Testbench for the string descriptor byte bank.
// Assumes the host model above and the bank's registered read port.
`timescale 1ns/1ps
`default_nettype none

module usb_string_descriptor_bank_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic serEn = 1'b0;
  logic [7:0] makerLen = 8'h00;
  logic [7:0] prodLen = 8'h00;
  usbsd_pkg::usbsd_cfg_s cfg = '0;
  logic [7:0] rdData;
  logic descReq;
  logic [7:0] descIndex;
  logic descBusy;
  logic descReject;
  usbsd_pkg::usbsd_byte_s descOut;
  int fails = 0;
  int n_checks = 0;

  always #2 clock = ~clock;

  usbsd_string_bank #(.SERIAL_DEFAULT({32{8'ha5}})) usbsd_string_bank_i (
    .clock(clock), .rst(rst), .custom_serial_enable(serEn),
    .maker_string_length(makerLen), .product_string_length(prodLen),
    .cfg(cfg), .rdData(rdData), .descReq(descReq), .descIndex(descIndex),
    .descBusy(descBusy), .descReject(descReject), .descOut(descOut));

  usbsd_host_model usbsd_host_model_i (
    .clock(clock), .descBusy(descBusy), .descReject(descReject),
    .descOut(descOut), .descReq(descReq), .descIndex(descIndex));

  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg <= '{1'b1, a, d};
    @(posedge clock);
    cfg.wrEn <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    cfg.addr <= a;
    @(posedge clock);
    #1;
    chk("rdData", e, rdData);
  endtask : rd

  // Runs one request and judges the count and two sample bytes
  task fetch_chk(input logic [7:0] idx, input logic [7:0] n, input logic [7:0] b0,
                 input logic [7:0] b1);
    usbsd_host_model_i.fetch(idx);
    chk("reject", 8'(n == 8'h00), {7'h00, usbsd_host_model_i.rej});
    chk("count", n, 8'(usbsd_host_model_i.nGot));
    chk("busy after", 8'h00, {7'h00, descBusy});
    chk("busy seen", 8'(n != 8'h00), {7'h00, usbsd_host_model_i.busySeen});
    chk("last seen", 8'(n != 8'h00), {7'h00, usbsd_host_model_i.lastSeen});
    if (n != 8'h00)
    begin
      chk("first byte", b0, usbsd_host_model_i.got[0]);
      chk("final byte", b1, usbsd_host_model_i.got[n - 1]);
    end
  endtask : fetch_chk

  task stop_test;
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task t_reset_and_map;
    rd(8'h30, 8'ha5);
    rd(8'h50, 8'h00);
    rd(8'hcf, 8'h00);
    wr(8'h8f, 8'h7e);
    rd(8'h8f, 8'h7e);
    wr(8'hcf, 8'h6d);
    rd(8'hcf, 8'h6d);
    wr(8'hd0, 8'h11);
    rd(8'hd0, 8'h00);
  endtask : t_reset_and_map

  task t_serial;
    wr(8'h30, 8'h31);
    rd(8'h30, 8'ha5);
    @(posedge clock);
    serEn <= 1'b1;
    wr(8'h30, 8'h31);
    wr(8'h4f, 8'h39);
    rd(8'h30, 8'h31);
    rd(8'h4f, 8'h39);
    @(posedge clock);
    serEn <= 1'b0;
    fetch_chk(8'h01, 8'd32, 8'h31, 8'h39);
  endtask : t_serial

  task t_strings;
    fetch_chk(8'h03, 8'h00, 8'h00, 8'h00);
    fetch_chk(8'h02, 8'h00, 8'h00, 8'h00);
    // UTF-16LE text, so every second byte of plain letters is zero
    wr(8'h50, 8'h41);
    wr(8'h51, 8'h00);
    wr(8'h52, 8'h42);
    wr(8'h54, 8'h43);
    wr(8'h90, 8'h50);
    wr(8'h91, 8'h00);
    makerLen <= 8'd4;
    prodLen <= 8'd2;
    fetch_chk(8'h03, 8'd4, 8'h41, 8'h00);
    fetch_chk(8'h02, 8'd2, 8'h50, 8'h00);
    fetch_chk(8'h04, 8'h00, 8'h00, 8'h00);
    // Over-long product length must stop at the array end, last byte at CFh
    @(posedge clock);
    makerLen <= 8'd1;
    prodLen <= 8'hc8;
    fetch_chk(8'h03, 8'd1, 8'h41, 8'h41);
    fetch_chk(8'h02, 8'd64, 8'h50, 8'h6d);
  endtask : t_strings

  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset_and_map;
    t_serial;
    t_strings;
    stop_test;
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    fails++;
    stop_test;
  end
endmodule : usb_string_descriptor_bank_tb

`default_nettype wire
